// ===== hdl/csort_cfg.svh
// Constants for the component sorter handshake block
`ifndef CSORT_CFG_SVH
`define CSORT_CFG_SVH
`define CSORT_NUM_CAT      10
`define CSORT_CAT_W        4
`define CSORT_LAST_CAT     4'h9
`define CSORT_CAT_NONE     10'h3ff
`define CSORT_SORT_NS      100
`define CSORT_CLK_NS       20
`define CSORT_SORT_CYC     ((`CSORT_SORT_NS + `CSORT_CLK_NS - 1) / `CSORT_CLK_NS)
`define CSORT_VERD_PASS    1'b1
`endif

// ===== hdl/csort_pkg.sv
// Types for the component sorter handshake block
package csort_pkg;
  typedef enum logic [1:0] {
    CSORT_NULL,
    CSORT_READY,
    CSORT_BUSY,
    CSORT_NOTBUSY
  } csort_state_e;

  typedef struct packed {
    logic       busy;
    logic       result_valid_n;
    logic [9:0] cat_n;
    logic       verdict;
  } csort_pins_s;

  typedef struct packed {
    logic       done;
    logic [8:0] cat_match;
    logic       pass;
  } csort_result_s;
endpackage : csort_pkg

// ===== hdl/csort_cat_pick.sv
// Lowest-numbered category picker, one-hot active-low output
`timescale 1ns/1ns
`default_nettype none
module csort_cat_pick #(
  parameter int NCAT = 10
) (
  input  wire logic [NCAT-2:0] match,
  output var  logic [NCAT-1:0] cat_n
);
  logic [NCAT-1:0] onehot;
  always_comb begin
    onehot = '0;
    for (int i = NCAT - 2; i >= 0; i--) begin
      if (match[i]) begin
        onehot    = '0;
        onehot[i] = 1'b1;
      end
    end
    if (match == '0) begin
      onehot[NCAT-1] = 1'b1;
    end
    cat_n = ~onehot;
  end
endmodule : csort_cat_pick
`default_nettype wire

// ===== hdl/csort_handshake.sv
// Sorting-handler port handshake sequencer
`timescale 1ns/1ns
`default_nettype none
`include "csort_cfg.svh"
module csort_handshake #(
  parameter int NCAT     = `CSORT_NUM_CAT,
  parameter int SORT_CYC = `CSORT_SORT_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    option_fitted,
  input  wire logic                    trigger_n,
  input  wire logic                    panel_trigger,
  input  wire logic                    remote_mode,
  input  wire logic                    local_trigger_enable_cmd,
  input  wire logic                    seq_mode,
  input  wire logic                    seq_last,
  input  wire csort_pkg::csort_result_s meas,
  output logic                         meas_start,
  output logic                         busy,
  output logic                         result_valid_n,
  output logic [NCAT-1:0]              cat_n,
  output logic                         verdict
);
  logic                   rst_s1_reg;
  logic                   rst_s2_reg;
  logic                   trig_s1_reg;
  logic                   trig_s2_reg;
  logic                   trig_s3_reg;
  csort_pkg::csort_state_e state_reg;
  csort_pkg::csort_state_e state_next;
  logic [7:0]             sort_cnt_reg;
  logic [7:0]             sort_cnt_next;
  logic [NCAT-1:0]        cat_pick;
  logic [NCAT-1:0]        cat_hold_reg;
  logic                   seq_fail_reg;
  logic                   verd_hold_reg;
  logic                   ext_edge;
  logic                   ext_ok;
  logic                   trig;
  logic                   sort_done;
  logic                   seq_end;
  logic                   verd_new;
  csort_pkg::csort_pins_s pins;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Trigger synchroniser and edge detect
  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
    end else begin
      trig_s1_reg <= trigger_n;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  assign ext_edge = trig_s3_reg & ~trig_s2_reg;
  assign ext_ok   = ~remote_mode | local_trigger_enable_cmd;
  assign trig     = option_fitted & (panel_trigger | (ext_edge & ext_ok));
  assign sort_done = (sort_cnt_reg == 8'(SORT_CYC - 1));
  assign seq_end  = ~seq_mode | seq_last;

  csort_cat_pick #(
    .NCAT (NCAT)
  ) u_pick (
    .match (meas.cat_match),
    .cat_n (cat_pick)
  );

  always_comb begin
    state_next    = state_reg;
    sort_cnt_next = 8'h00;
    unique case (state_reg)
      csort_pkg::CSORT_NULL: begin
        if (option_fitted) begin
          state_next = csort_pkg::CSORT_READY;
        end
        if (trig) begin
          state_next = csort_pkg::CSORT_BUSY;
        end
      end
      csort_pkg::CSORT_READY: begin
        if (trig) begin
          state_next = csort_pkg::CSORT_BUSY;
        end
      end
      csort_pkg::CSORT_BUSY: begin
        if (meas.done && !trig) begin
          state_next = csort_pkg::CSORT_NOTBUSY;
        end
      end
      csort_pkg::CSORT_NOTBUSY: begin
        sort_cnt_next = sort_cnt_reg + 8'h01;
        if (trig) begin
          state_next = csort_pkg::CSORT_BUSY;
        end else if (sort_done) begin
          state_next = csort_pkg::CSORT_READY;
        end
      end
    endcase
  end

  // Sequence verdict accumulates failures until last step
  assign verd_new = seq_mode ? (~seq_fail_reg & meas.pass) : meas.pass;

  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      state_reg     <= csort_pkg::CSORT_NULL;
      sort_cnt_reg  <= 8'h00;
      cat_hold_reg  <= `CSORT_CAT_NONE;
      seq_fail_reg  <= 1'b0;
      verd_hold_reg <= `CSORT_VERD_PASS;
    end else begin
      state_reg    <= state_next;
      sort_cnt_reg <= sort_cnt_next;
      if (state_reg == csort_pkg::CSORT_BUSY && meas.done && !trig) begin
        cat_hold_reg <= cat_pick;
        seq_fail_reg <= seq_end ? 1'b0 : (seq_fail_reg | ~meas.pass);
        if (seq_end) begin
          verd_hold_reg <= verd_new;
        end
      end
    end
  end

  // Output pin levels per state
  always_comb begin
    pins.busy           = 1'b0;
    pins.result_valid_n = 1'b1;
    pins.cat_n          = `CSORT_CAT_NONE;
    pins.verdict        = verd_hold_reg;
    unique case (state_next)
      csort_pkg::CSORT_NULL: begin
        pins.busy           = 1'b0;
        pins.result_valid_n = 1'b1;
      end
      csort_pkg::CSORT_READY: begin
        pins.busy           = 1'b1;
        pins.result_valid_n = 1'b0;
        pins.cat_n          = (state_reg == csort_pkg::CSORT_NULL) ? `CSORT_CAT_NONE : cat_hold_reg;
      end
      csort_pkg::CSORT_BUSY: begin
        pins.busy           = 1'b0;
        pins.result_valid_n = 1'b0;
        pins.cat_n          = cat_n;
      end
      csort_pkg::CSORT_NOTBUSY: begin
        pins.busy           = 1'b1;
        pins.result_valid_n = 1'b1;
        pins.cat_n          = `CSORT_CAT_NONE;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      busy           <= 1'b0;
      result_valid_n <= 1'b1;
      cat_n          <= `CSORT_CAT_NONE;
      verdict        <= `CSORT_VERD_PASS;
      meas_start     <= 1'b0;
    end else begin
      busy           <= pins.busy;
      result_valid_n <= pins.result_valid_n;
      cat_n          <= pins.cat_n;
      verdict        <= (state_next == csort_pkg::CSORT_READY) ? verd_hold_reg : verdict;
      meas_start     <= trig;
    end
  end
endmodule : csort_handshake
`default_nettype wire

// ===== tb/csort_handshake_asserts.sv
// Handshake checks for the sorter port
`timescale 1ns/1ns
`default_nettype none
module csort_handshake_asserts #(
  parameter int NCAT     = 10,
  parameter int SORT_CYC = 5
) (
  input wire logic                    mclk,
  input wire logic                    rst_b,
  input wire logic                    option_fitted,
  input wire logic                    trigger_n,
  input wire logic                    panel_trigger,
  input wire logic                    remote_mode,
  input wire logic                    local_trigger_enable_cmd,
  input wire logic                    seq_mode,
  input wire logic                    seq_last,
  input wire csort_pkg::csort_result_s meas,
  input wire logic                    meas_start,
  input wire logic                    busy,
  input wire logic                    result_valid_n,
  input wire logic [NCAT-1:0]         cat_n,
  input wire logic                    verdict
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_done;
    !busy && !result_valid_n && meas.done && !panel_trigger && trigger_n;
  endsequence
  sequence s_sort;
    $rose(busy) && result_valid_n;
  endsequence
  a_start_ack: assert property (meas_start |-> !busy && !result_valid_n)
    else $error("busy not low at start");
  a_done_sort: assert property (s_done |=> busy && result_valid_n && &cat_n)
    else $error("no not-busy after done");
  a_sort_ready: assert property (s_sort |-> ##SORT_CYC (busy && !result_valid_n))
    else $error("ready late or early");
  a_cat_onehot: assert property (!result_valid_n |-> $onehot0(~cat_n))
    else $error("several categories low");
  a_cat_invalid: assert property (result_valid_n |-> &cat_n)
    else $error("category low while invalid");
  a_valid_edge: assert property ($fell(result_valid_n) |-> busy)
    else $error("strobe fell outside ready");
  a_busy_rise: assert property ($rose(busy) |-> $past(meas.done) || $past(result_valid_n))
    else $error("busy rose without done");
  a_panel_ack: assert property (panel_trigger && option_fitted && !remote_mode |=> meas_start)
    else $error("panel trigger not taken");
  a_remote_block: assert property ((remote_mode && !local_trigger_enable_cmd && !panel_trigger)[*5]
    |-> !meas_start)
    else $error("external trigger in remote");
  a_verdict_time: assert property (!$stable(verdict) |-> busy && !result_valid_n)
    else $error("verdict moved outside ready");
endmodule : csort_handshake_asserts
bind csort_handshake csort_handshake_asserts #(.NCAT(NCAT), .SORT_CYC(SORT_CYC)) csort_handshake_asserts_inst (.*);
`default_nettype wire

// ===== tb/csort_handler.sv
// Sorting handler model
`timescale 1ns/1ns
`default_nettype none
module csort_handler (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic       result_valid_n,
  input  wire logic [9:0] cat_n,
  output wire logic       trigger_n,
  output var  logic [9:0] got
);
  logic rv_q = 1'b1;
  initial got = 10'h3ff;
  // Driven high when released
  assign trigger_n = ~go;
  always @(posedge mclk) begin
    rv_q <= result_valid_n;
    if (rv_q && !result_valid_n) got <= cat_n;
  end
endmodule : csort_handler
`default_nettype wire

// ===== tb/csort_handshake_tb.sv
// Testbench for the sorter handshake block
`timescale 1ns/1ns
`default_nettype none
module csort_handshake_tb;
  logic mclk = 0, rst_b = 0, pt = 0, rm = 0, le = 0, sm = 0, sl = 0, go = 0;
  csort_pkg::csort_result_s meas = '0;
  csort_pkg::csort_pins_s   pins;
  logic tn, ms, bz, rv, vd;
  logic [9:0] cn, got;
  int fails = 0, n_checks = 0, cyc = 0;
  assign pins = {bz, rv, cn, vd};
  csort_handshake csort_handshake_inst (.mclk(mclk), .rst_b(rst_b), .option_fitted(1'b1),
    .trigger_n(tn), .panel_trigger(pt), .remote_mode(rm), .local_trigger_enable_cmd(le),
    .seq_mode(sm), .seq_last(sl), .meas(meas), .meas_start(ms), .busy(bz),
    .result_valid_n(rv), .cat_n(cn), .verdict(vd));
  csort_handler csort_handler_inst (.mclk(mclk), .go(go), .result_valid_n(rv), .cat_n(cn),
    .trigger_n(tn), .got(got));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic final_report;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input csort_pkg::csort_pins_s g, e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic done(input logic [8:0] m, input logic p, l);
    meas = {1'b1, m, p};
    sl = l;
    @(negedge mclk) meas = '0;
    sl = 0;
    repeat (7) @(negedge mclk);
  endtask : done
  task automatic run(input logic [8:0] m, input logic p, l);
    @(negedge mclk) pt = 1;
    @(negedge mclk) pt = 0;
    repeat (2) @(negedge mclk);
    done(m, p, l);
  endtask : run
  task automatic t_cat;
    logic [8:0] m [4] = '{9'h000, 9'h001, 9'h006, 9'h100};
    logic [9:0] e [4] = '{10'h1ff, 10'h3fe, 10'h3fd, 10'h2ff};
    for (int i = 0; i < 4; i++) begin
      run(m[i], i[0], 0);
      chk(pins, {2'b10, e[i], i[0]});
    end
  endtask : t_cat
  task automatic t_abort;
    @(negedge mclk) pt = 1;
    @(negedge mclk) pt = 0;
    repeat (3) @(negedge mclk);
    run(9'h002, 1, 0);
    chk(pins, {2'b10, 10'h3fd, 1'b1});
  endtask : t_abort
  task automatic t_ext(input logic r, e, input int x);
    int n = 0;
    rm = r;
    le = e;
    @(negedge mclk) go = 1;
    repeat (12) @(negedge mclk) n += ms;
    go = 0;
    chk(13'(n), 13'(x));
    if (x == 1) begin
      done(9'h010, 1, 0);
      chk(pins, {2'b10, 10'h3ef, 1'b1});
      chk({3'h0, got}, {3'h0, 10'h3ef});
    end
  endtask : t_ext
  task automatic t_seq;
    sm = 1;
    run(9'h001, 0, 0);
    chk(pins, {2'b10, 10'h3fe, 1'b1});
    run(9'h001, 1, 1);
    chk(pins, {2'b10, 10'h3fe, 1'b0});
  endtask : t_seq
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    repeat (6) @(negedge mclk);
    chk(pins, {2'b01, 10'h3ff, 1'b1});
    rst_b = 1;
    repeat (6) @(negedge mclk);
    chk(pins, {2'b10, 10'h3ff, 1'b1});
    t_cat;
    t_abort;
    t_ext(1, 0, 0);
    t_ext(1, 1, 1);
    t_ext(0, 0, 1);
    t_seq;
    final_report;
  end
endmodule : csort_handshake_tb
`default_nettype wire
